// >>> logic/rem_event_arb.sv
`timescale 1ns/1ns
// Picks the lowest numbered pending and enabled event.
module rem_event_arb #(
    parameter int N = 134,
    parameter int W = 8
) (
    input  wire logic [N-1:0] req,
    output logic              found,
    output logic [W-1:0]      idx
);

    // ------------------------------------------------------------------
    // Priority search
    // ------------------------------------------------------------------
    // Lowest number wins so link health events are never starved.
    always_comb begin
        found = 1'b0;
        idx   = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                found = 1'b1;
                idx   = W'(i);
            end
        end
    end

endmodule // rem_event_arb

// >>> logic/rem_event_map.sv
`timescale 1ns/1ns
// What this block does
// - Message word is 64 bits, fixed layout
// - Push size 0b11; start, data, end types
// - Events 0-2: link ok, error, fatal
// - Events 3-8: shell and pixel conditions
// - 9 recal, 10 reset; 11-12 unconnected
// - Events 15-18: link handler mailbox, push
// - Events 19-26: link handler error events
// - Events 27-38: same for Ethernet handler
// - Events 39-42: Ethernet drops, MAC update
// - 43 combined FIFO; 50-53 data written
// - Events 54-85: per channel FIFO conditions
// - Events 86-101: reload timers 0-15
// - Events 105-120: pulse generators 0-3
// - 125 sound, 126 sound reload
// - 127-129 converter end, scan, compare
// - Routed interrupt sends one event message
// - Payload setup at table 0x400 plus 4n
module rem_event_map
    import rem_pkg::*;
#(
    parameter int NEV = rem_pkg::NUM_EVENTS
) (
    input  wire logic                       sys_clk,
    input  wire logic                       srst,
    input  wire logic                       clk_en,
    input  wire logic [2:0]                 link_status_irq,
    input  wire logic [5:0]                 shell_irq,
    input  wire logic                       phy_recal_req,
    input  wire logic                       phy_reset_req,
    input  wire logic [11:0]                link_handler_irq,
    input  wire logic [11:0]                eth_handler_irq,
    input  wire logic [3:0]                 eth_mac_irq,
    input  wire logic                       cfg_fifo_combined_irq,
    input  wire logic [3:0]                 cfg_fifo_data_written,
    input  wire logic [31:0]                cfg_fifo_channel_irq,
    input  wire logic [15:0]                reload_timer_irq,
    input  wire logic [15:0]                pulse_gen_irq,
    input  wire logic [1:0]                 sound_gen_irq,
    input  wire logic [2:0]                 adc_irq,
    input  wire logic [11:0]                reg_addr,
    input  wire logic [31:0]                reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic [31:0]                     reg_rdata,
    output logic                            msg_valid,
    input  wire logic                       msg_ready,
    output logic [rem_pkg::MSG_W-1:0]       msg_data
);

    // ------------------------------------------------------------------
    // Event input vector
    // ------------------------------------------------------------------
    logic [NEV-1:0] ev_in;

    // Each source is placed at its fixed event number; gaps read zero.
    always_comb begin
        ev_in = '0;
        ev_in[int'(EV_LINK_FUNC) +: 3] = link_status_irq;
        ev_in[int'(EV_SHELL_REQ) +: 6] = shell_irq;
        ev_in[int'(EV_PHY_RECAL)]      = phy_recal_req;
        ev_in[int'(EV_PHY_RESET)]      = phy_reset_req;
        ev_in[int'(EV_NC1)]            = 1'b0;
        ev_in[int'(EV_NC2)]            = 1'b0;
        ev_in[int'(EV_LINK_HDL) +: HANDLER_EVENTS] = link_handler_irq;
        ev_in[int'(EV_ETH_HDL) +: HANDLER_EVENTS]  = eth_handler_irq;
        ev_in[int'(EV_ETH_MAC) +: 4]   = eth_mac_irq;
        ev_in[int'(EV_CFG_ALL)]        = cfg_fifo_combined_irq;
        // Data written channels sit from channel 3 down to channel 0.
        for (int c = 0; c < 4; c++) begin
            ev_in[int'(EV_CFG_DW) + 3 - c] = cfg_fifo_data_written[c];
        end
        // Four events per channel, channel 7 first; bit 4c+k of the port is
        // channel c, k = 0 underflow, 1 overflow, 2 upper, 3 lower.
        for (int c = 0; c < 8; c++) begin
            for (int k = 0; k < 4; k++) begin
                ev_in[int'(EV_CFG_CH) + 4 * (7 - c) + k] = cfg_fifo_channel_irq[4 * c + k];
            end
        end
        ev_in[int'(EV_TIMER) +: 16]    = reload_timer_irq;
        ev_in[int'(EV_PULSE) +: 16]    = pulse_gen_irq;
        ev_in[int'(EV_SOUND) +: 2]     = sound_gen_irq;
        ev_in[int'(EV_ADC) +: 3]       = adc_irq;
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [31:0]    ctrl_q;
    logic [7:0]     push_idx_q;
    logic [2:0]     push_type_q;
    logic [NEV-1:0] enable_q;
    logic [NEV-1:0] pending_q;
    logic [31:0]    table_q [NEV];
    logic [31:0]    push_data_q;
    logic           push_req_q;
    rem_state_t     state_q;
    logic [EV_W-1:0] sel_q;
    logic [7:0]     midx_q;
    logic [31:0]    payload_q;

    localparam int NWORDS = (NEV + 31) / 32;

    // Word index of a register group access, or out of range.
    function automatic int word_of(input logic [11:0] a, input logic [11:0] base);
        word_of = (a >= base && a < base + 12'(4 * NWORDS)) ? int'((a - base) >> 2) : -1;
    endfunction

    function automatic int table_of(input logic [11:0] a);
        table_of = (a >= REG_MSG_TABLE && a < REG_TABLE_END) ?
                   int'((a - REG_MSG_TABLE) >> 2) : -1;
    endfunction

    // Control, push setup and event enables.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ctrl_q      <= CTRL_RESET;
            push_idx_q  <= '0;
            push_type_q <= PT_ONE_DATA;
            enable_q    <= '0;
        end else if (clk_en && reg_wr) begin
            if (reg_addr == REG_CTRL) begin
                ctrl_q <= reg_wdata;
            end
            if (reg_addr == REG_PUSH_IDX) begin
                push_idx_q <= reg_wdata[7:0];
            end
            if (reg_addr == REG_PUSH_TYPE) begin
                push_type_q <= reg_wdata[2:0];
            end
            for (int w = 0; w < NWORDS; w++) begin
                if (word_of(reg_addr, REG_EN0) == w) begin
                    for (int b = 0; b < 32; b++) begin
                        if (32 * w + b < NEV) begin
                            enable_q[32 * w + b] <= reg_wdata[b];
                        end
                    end
                end
            end
        end
    end

    // Payload lookup table, one word per event.
    always_ff @(posedge sys_clk) begin
        if (clk_en && reg_wr && table_of(reg_addr) >= 0) begin
            table_q[table_of(reg_addr)] <= reg_wdata;
        end
    end

    // Read data stands in the cycle after the strobe only.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            reg_rdata <= '0;
        end else if (clk_en) begin
            reg_rdata <= '0;
            if (reg_rd) begin
                if (reg_addr == REG_CTRL) begin
                    reg_rdata <= ctrl_q;
                end else if (reg_addr == REG_PUSH_IDX) begin
                    reg_rdata <= {24'h0, push_idx_q};
                end else if (reg_addr == REG_PUSH_TYPE) begin
                    reg_rdata <= {29'h0, push_type_q};
                end else if (table_of(reg_addr) >= 0) begin
                    reg_rdata <= table_q[table_of(reg_addr)];
                end
                for (int w = 0; w < NWORDS; w++) begin
                    for (int b = 0; b < 32; b++) begin
                        if (32 * w + b < NEV && word_of(reg_addr, REG_STAT0) == w) begin
                            reg_rdata[b] <= pending_q[32 * w + b];
                        end
                        if (32 * w + b < NEV && word_of(reg_addr, REG_EN0) == w) begin
                            reg_rdata[b] <= enable_q[32 * w + b];
                        end
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Pending events and arbitration
    // ------------------------------------------------------------------
    logic            arb_found;
    logic [EV_W-1:0] arb_idx;
    logic            ev_go;
    logic            push_go;
    logic            done;

    assign ev_go   = state_q == REM_IDLE && arb_found && ctrl_q[CTRL_EVENT_EN_BIT];
    assign push_go = state_q == REM_IDLE && !ev_go && push_req_q;
    assign done    = state_q == REM_SEND && msg_ready;

    // An input sets its pending bit only while enabled; taking it clears it.
    // A fresh edge in the take cycle still sets, so no event is lost.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pending_q <= '0;
        end else if (clk_en) begin
            for (int i = 0; i < NEV; i++) begin
                if (ev_in[i] && enable_q[i]) begin
                    pending_q[i] <= 1'b1;
                end else if (ev_go && arb_idx == EV_W'(i)) begin
                    pending_q[i] <= 1'b0;
                end
            end
        end
    end

    rem_event_arb #(
        .N (NEV),
        .W (EV_W)
    ) u_arb (
        .req   (pending_q & enable_q),
        .found (arb_found),
        .idx   (arb_idx)
    );

    // Software push data word; one outstanding word at a time.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            push_req_q  <= 1'b0;
            push_data_q <= '0;
        end else if (clk_en) begin
            if (reg_wr && reg_addr == REG_PUSH_MSG && ctrl_q[CTRL_PUSH_EN_BIT]) begin
                push_req_q  <= 1'b1;
                push_data_q <= reg_wdata;
            end else if (push_go) begin
                push_req_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Message sender
    // ------------------------------------------------------------------
    // Fetch takes one cycle so the table read is registered.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_q   <= REM_IDLE;
            sel_q     <= '0;
            payload_q <= '0;
            midx_q    <= '0;
            msg_data  <= '0;
        end else if (clk_en) begin
            case (state_q)
                REM_IDLE: begin
                    if (ev_go) begin
                        sel_q   <= arb_idx;
                        state_q <= REM_FETCH;
                    end else if (push_go) begin
                        msg_data <= rem_pack(push_type_q, push_idx_q, midx_q,
                                             push_data_q);
                        state_q  <= REM_SEND;
                    end
                end
                REM_FETCH: begin
                    payload_q <= table_q[sel_q];
                    msg_data  <= rem_pack(PT_EVENT, sel_q, midx_q,
                                          table_q[sel_q]);
                    state_q   <= REM_SEND;
                end
                REM_SEND: begin
                    if (msg_ready) begin
                        midx_q  <= midx_q + 8'h01;
                        state_q <= REM_IDLE;
                    end
                end
                default: begin
                    state_q <= REM_IDLE;
                end
            endcase
        end
    end

    assign msg_valid = state_q == REM_SEND;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_msg_size_fixed: assert property (@(posedge sys_clk) disable iff (srst)
        msg_valid |-> msg_data[SIZE_HI:SIZE_LO] == SIZE_PUSH_EVENT)
        else $error("message size code wrong");
    a_msg_rsv_zero: assert property (@(posedge sys_clk) disable iff (srst)
        msg_valid |-> msg_data[RSV_HI:RSV_LO] == 8'h00 && !msg_data[OWN_BIT] && !msg_data[WR_BIT])
        else $error("reserved or flag bits set");
    a_event_sent: assert property (@(posedge sys_clk) disable iff (srst)
        (clk_en && ev_go) ##1 clk_en |=> msg_valid)
        else $error("event not sent");
    a_event_clears: assert property (@(posedge sys_clk) disable iff (srst)
        (clk_en && ev_go && !ev_in[arb_idx]) |=> !pending_q[$past(arb_idx)])
        else $error("pending not cleared");
    a_disabled_idle: assert property (@(posedge sys_clk) disable iff (srst)
        (clk_en && !enable_q[0] && !pending_q[0]) |=> !pending_q[0])
        else $error("disabled event pending");
    a_event_index: assert property (@(posedge sys_clk) disable iff (srst)
        (clk_en && state_q == REM_FETCH) |=> msg_data[PIDX_HI:PIDX_LO] == $past(sel_q)
        && msg_data[DATA_HI:0] == payload_q && msg_data[PTYPE_HI:PTYPE_LO] == PT_EVENT)
        else $error("event word wrong");
    a_send_hold: assert property (@(posedge sys_clk) disable iff (srst)
        (msg_valid && !msg_ready) |=> msg_valid && $stable(msg_data))
        else $error("message dropped");
    a_nc_unused: assert property (@(posedge sys_clk) disable iff (srst)
        !pending_q[EV_NC1] && !pending_q[EV_NC2])
        else $error("unconnected event pending");
    c_event_msg: cover property (@(posedge sys_clk) ev_go ##2 done);
    c_push_msg: cover property (@(posedge sys_clk) push_go ##1 done);
    c_stall: cover property (@(posedge sys_clk) msg_valid && !msg_ready ##1 done);

endmodule // rem_event_map

// >>> logic/rem_pkg.sv
package rem_pkg;

    // ------------------------------------------------------------------
    // Message word layout
    // ------------------------------------------------------------------
    localparam int MSG_W          = 64;
    localparam int RSV_HI         = 63;
    localparam int RSV_LO         = 56;
    localparam int SIZE_HI        = 55;
    localparam int SIZE_LO        = 54;
    localparam int OWN_BIT        = 53;
    localparam int WR_BIT         = 52;
    localparam int ERR_BIT        = 51;
    localparam int PTYPE_HI       = 50;
    localparam int PTYPE_LO       = 48;
    localparam int PIDX_HI        = 47;
    localparam int PIDX_LO        = 40;
    localparam int MIDX_HI        = 39;
    localparam int MIDX_LO        = 32;
    localparam int DATA_HI        = 31;

    localparam logic [1:0] SIZE_PUSH_EVENT = 2'h3;
    // Push type codes: bit0 data, bit1 start, bit2 end.
    localparam logic [2:0] PT_EVENT    = 3'h0;
    localparam logic [2:0] PT_DATA     = 3'h1;
    localparam logic [2:0] PT_SOP_DATA = 3'h3;
    localparam logic [2:0] PT_EOP_DATA = 3'h5;
    localparam logic [2:0] PT_ONE_DATA = 3'h7;

    // ------------------------------------------------------------------
    // Event numbering and lookup table
    // ------------------------------------------------------------------
    localparam int NUM_EVENTS     = 134;
    localparam int EV_W           = 8;
    localparam logic [EV_W-1:0] EV_LINK_FUNC   = 8'h00;
    localparam logic [EV_W-1:0] EV_SHELL_REQ   = 8'h03;
    localparam logic [EV_W-1:0] EV_PHY_RECAL   = 8'h09;
    localparam logic [EV_W-1:0] EV_PHY_RESET   = 8'h0A;
    localparam logic [EV_W-1:0] EV_NC1         = 8'h0B;
    localparam logic [EV_W-1:0] EV_NC2         = 8'h0C;
    localparam logic [EV_W-1:0] EV_LINK_HDL    = 8'h0F;
    localparam logic [EV_W-1:0] EV_ETH_HDL     = 8'h1B;
    localparam logic [EV_W-1:0] EV_ETH_MAC     = 8'h27;
    localparam logic [EV_W-1:0] EV_CFG_ALL     = 8'h2B;
    localparam logic [EV_W-1:0] EV_CFG_DW      = 8'h32;
    localparam logic [EV_W-1:0] EV_CFG_CH      = 8'h36;
    localparam logic [EV_W-1:0] EV_TIMER       = 8'h56;
    localparam logic [EV_W-1:0] EV_PULSE       = 8'h69;
    localparam logic [EV_W-1:0] EV_SOUND       = 8'h7D;
    localparam logic [EV_W-1:0] EV_ADC         = 8'h7F;
    localparam int HANDLER_EVENTS = 12;
    localparam int TABLE_OFFSET   = 'h400;

    // ------------------------------------------------------------------
    // Register map (word aligned byte offsets)
    // ------------------------------------------------------------------
    localparam logic [11:0] REG_CTRL      = 12'h000;
    localparam logic [11:0] REG_PUSH_MSG  = 12'h034;
    localparam logic [11:0] REG_PUSH_IDX  = 12'h038;
    localparam logic [11:0] REG_PUSH_TYPE = 12'h03C;
    localparam logic [11:0] REG_STAT0     = 12'h048;
    localparam logic [11:0] REG_EN0       = 12'h068;
    localparam logic [11:0] REG_MSG_TABLE = 12'h400;
    localparam logic [11:0] REG_TABLE_END = 12'h618;
    localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
    localparam int CTRL_EVENT_EN_BIT      = 0;
    localparam int CTRL_PUSH_EN_BIT       = 1;

    typedef enum logic [2:0] {
        REM_IDLE  = 3'b001,
        REM_FETCH = 3'b010,
        REM_SEND  = 3'b100
    } rem_state_t;

    // Builds one 64-bit outgoing message word.
    function automatic logic [MSG_W-1:0] rem_pack(input logic [2:0]  ptype,
                                                  input logic [7:0]  pidx,
                                                  input logic [7:0]  midx,
                                                  input logic [31:0] data);
        rem_pack = {8'h00, SIZE_PUSH_EVENT, 1'b0, 1'b0, 1'b0, ptype, pidx, midx, data};
    endfunction

endpackage

// >>> tb/rem_host_model.sv
`timescale 1ns/1ns
// ------------------------------------------------------------------
// Host side sink for the outgoing message words
// ------------------------------------------------------------------
module rem_host_model
    import rem_pkg::*;
(
    input  wire logic                    sys_clk,
    input  wire logic                    srst,
    input  wire logic                    slow,
    input  wire logic                    msg_valid,
    output logic                         msg_ready,
    input  wire logic [rem_pkg::MSG_W-1:0] msg_data,
    output logic                         rx_stb,
    output logic [rem_pkg::MSG_W-1:0]    rx_word,
    output logic [31:0]                  rx_count,
    output logic [31:0]                  frames
);
    logic [255:0] open_q;
    logic         push_w;

    // A push word carries the push size and a non-zero type; events have type zero.
    assign push_w = (msg_data[SIZE_HI:SIZE_LO] == 2'h3) && (msg_data[PTYPE_HI:PTYPE_LO] != 3'h0);

    // Ready toggles in slow mode so the sender must hold its word across stalls.
    always_ff @(posedge sys_clk) begin
        if (srst) msg_ready <= 1'b0;
        else      msg_ready <= slow ? ~msg_ready : 1'b1;
    end

    // Every taken word is handed to the bench as a one cycle strobe.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rx_stb   <= 1'b0;
            rx_word  <= '0;
            rx_count <= '0;
        end else begin
            rx_stb <= msg_valid & msg_ready;
            if (msg_valid && msg_ready) begin
                rx_word  <= msg_data;
                rx_count <= rx_count + 32'h1;
            end
        end
    end

    // Frames are rebuilt per push index; an end counts after its start or when it carries its own start.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            open_q <= '0;
            frames <= '0;
        end else if (msg_valid && msg_ready && push_w) begin
            if (msg_data[PTYPE_LO+1]) open_q[msg_data[PIDX_HI:PIDX_LO]] <= 1'b1;
            if (msg_data[PTYPE_HI] && (open_q[msg_data[PIDX_HI:PIDX_LO]] || msg_data[PTYPE_LO+1])) begin
                open_q[msg_data[PIDX_HI:PIDX_LO]] <= 1'b0;
                frames <= frames + 32'h1;
            end
        end
    end
endmodule // rem_host_model

// >>> tb/test_remote_event_map_push_format.sv
`timescale 1ns/1ns
// ------------------------------------------------------------------
// Bench for the event mapper and push message path
// ------------------------------------------------------------------
module test_remote_event_map_push_format;
    import rem_pkg::*;
    logic sys_clk, srst, clk_en, slow, msg_valid, msg_ready, rx_stb, reg_wr, reg_rd;
    logic [2:0] link_status_irq, adc_irq;
    logic [5:0] shell_irq;
    logic phy_recal_req, phy_reset_req, cfg_fifo_combined_irq;
    logic [11:0] link_handler_irq, eth_handler_irq, reg_addr;
    logic [3:0] eth_mac_irq, cfg_fifo_data_written;
    logic [31:0] cfg_fifo_channel_irq, reg_wdata, reg_rdata, rx_count, frames, d;
    logic [15:0] reload_timer_irq, pulse_gen_irq;
    logic [1:0] sound_gen_irq;
    logic [MSG_W-1:0] msg_data, rx_word;
    logic [7:0] midx;
    int miscompares = 0, cmp_count = 0, cyc = 0;

    rem_event_map u_dut (.sys_clk(sys_clk), .srst(srst), .clk_en(clk_en),
        .link_status_irq(link_status_irq), .shell_irq(shell_irq), .phy_recal_req(phy_recal_req),
        .phy_reset_req(phy_reset_req), .link_handler_irq(link_handler_irq),
        .eth_handler_irq(eth_handler_irq), .eth_mac_irq(eth_mac_irq),
        .cfg_fifo_combined_irq(cfg_fifo_combined_irq), .cfg_fifo_data_written(cfg_fifo_data_written),
        .cfg_fifo_channel_irq(cfg_fifo_channel_irq), .reload_timer_irq(reload_timer_irq),
        .pulse_gen_irq(pulse_gen_irq), .sound_gen_irq(sound_gen_irq), .adc_irq(adc_irq),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .msg_valid(msg_valid), .msg_ready(msg_ready), .msg_data(msg_data));
    rem_host_model u_host (.sys_clk(sys_clk), .srst(srst), .slow(slow), .msg_valid(msg_valid),
        .msg_ready(msg_ready), .msg_data(msg_data), .rx_stb(rx_stb), .rx_word(rx_word),
        .rx_count(rx_count), .frames(frames));

    // The clock runs at 125 MHz.
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // A hung run is cut short well beyond the roughly 1100 cycles needed.
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (miscompares == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk64(input logic [MSG_W-1:0] got, input logic [MSG_W-1:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: message %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk32(reg_rdata, exp);
    endtask

    // Drives the source line of event n; unmapped numbers are left alone.
    task automatic set_ev(input int n, input logic v);
        if (n < 3) link_status_irq[n] <= v;
        else if (n < 9) shell_irq[n-3] <= v;
        else if (n == 9) phy_recal_req <= v;
        else if (n == 10) phy_reset_req <= v;
        else if (n >= 15 && n < 27) link_handler_irq[n-15] <= v;
        else if (n >= 27 && n < 39) eth_handler_irq[n-27] <= v;
        else if (n >= 39 && n < 43) eth_mac_irq[n-39] <= v;
        else if (n == 43) cfg_fifo_combined_irq <= v;
        else if (n >= 50 && n < 54) cfg_fifo_data_written[53-n] <= v;
        else if (n >= 54 && n < 86) cfg_fifo_channel_irq[4*(7-(n-54)/4)+(n-54)%4] <= v;
        else if (n >= 86 && n < 102) reload_timer_irq[n-86] <= v;
        else if (n >= 105 && n < 121) pulse_gen_irq[n-105] <= v;
        else if (n >= 125 && n < 127) sound_gen_irq[n-125] <= v;
        else if (n >= 127 && n < 130) adc_irq[n-127] <= v;
    endtask

    function automatic bit live(input int n);
        return !((n > 10 && n < 15) || (n > 43 && n < 50) || (n > 101 && n < 105) ||
                 (n > 120 && n < 125) || n > 129);
    endfunction

    task automatic fire(input int n);
        @(posedge sys_clk) set_ev(n, 1'b1);
        @(posedge sys_clk) set_ev(n, 1'b0);
    endtask

    // Waits a bounded time for the host to take a word, then compares it.
    task automatic expect_msg(input logic [2:0] t, input logic [7:0] idx, input logic [31:0] v);
        int k;
        for (k = 0; k < 40 && rx_stb !== 1'b1; k++) begin
            @(posedge sys_clk);
            #1;
        end
        chk64(rx_word, {8'h00, 2'h3, 3'h0, t, idx, midx, v});
        midx++;
        // Step past the edge so a back to back call never sees this strobe again.
        @(posedge sys_clk);
        #1;
    endtask

    task automatic t_reset();
        rd(REG_CTRL, 32'h0000_0000);
        rd(REG_PUSH_TYPE, 32'h0000_0007);
        rd(12'h200, 32'h0000_0000);
        chk32(rx_count, 32'h0);
    endtask

    task automatic t_map();
        wr(REG_CTRL, 32'h0000_0001);
        for (int w = 0; w < 5; w++) wr(REG_EN0 + 12'(4*w), 32'hFFFF_FFFF);
        rd(REG_EN0, 32'hFFFF_FFFF);
        for (int n = 0; n < 134; n++) wr(REG_MSG_TABLE + 12'(4*n), 32'hC0DE_0000 + 32'(n));
        rd(REG_MSG_TABLE + 12'h14, 32'hC0DE_0005);
        for (int n = 0; n < 134; n++) begin
            if (live(n)) begin
                fire(n);
                expect_msg(PT_EVENT, 8'(n), 32'hC0DE_0000 + 32'(n));
            end
        end
    endtask

    task automatic t_disabled();
        wr(REG_EN0, 32'h0000_0000);
        d = rx_count;
        fire(16);
        repeat (20) @(posedge sys_clk);
        chk32(rx_count, d);
        rd(REG_STAT0, 32'h0000_0000);
        wr(REG_EN0, 32'hFFFF_FFFF);
    endtask

    // Two sources at once with a stalling host: lowest number first, one word each.
    task automatic t_prio();
        slow <= 1'b1;
        @(posedge sys_clk);
        set_ev(86, 1'b1);
        set_ev(40, 1'b1);
        @(posedge sys_clk);
        set_ev(86, 1'b0);
        set_ev(40, 1'b0);
        expect_msg(PT_EVENT, 8'd40, 32'hC0DE_0028);
        expect_msg(PT_EVENT, 8'd86, 32'hC0DE_0056);
        repeat (20) @(posedge sys_clk);
        chk32(rx_count, d + 32'h2);
        slow <= 1'b0;
    endtask

    task automatic t_push();
        logic [2:0] ty [3] = '{PT_SOP_DATA, PT_DATA, PT_EOP_DATA};
        d = rx_count;
        wr(REG_PUSH_MSG, 32'h1111_2222);
        repeat (20) @(posedge sys_clk);
        chk32(rx_count, d);
        wr(REG_CTRL, 32'h0000_0003);
        wr(REG_PUSH_IDX, 32'h0000_0007);
        for (int i = 0; i < 3; i++) begin
            wr(REG_PUSH_TYPE, 32'(ty[i]));
            wr(REG_PUSH_MSG, 32'hDA7A_0000 + 32'(i));
            expect_msg(ty[i], 8'h07, 32'hDA7A_0000 + 32'(i));
        end
        chk32(frames, 32'h1);
    endtask

    // Main sequence: reset for five cycles, then each scenario in turn.
    initial begin
        srst = 1'b1; clk_en = 1'b1; slow = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0;
        reg_addr = '0; reg_wdata = '0; midx = '0;
        link_status_irq = '0; shell_irq = '0; phy_recal_req = 1'b0; phy_reset_req = 1'b0;
        link_handler_irq = '0; eth_handler_irq = '0; eth_mac_irq = '0; adc_irq = '0;
        cfg_fifo_combined_irq = 1'b0; cfg_fifo_data_written = '0; cfg_fifo_channel_irq = '0;
        reload_timer_irq = '0; pulse_gen_irq = '0; sound_gen_irq = '0;
        repeat (5) @(posedge sys_clk);
        srst <= 1'b0;
        t_reset();
        t_map();
        t_disabled();
        t_prio();
        t_push();
        print_verdict();
    end
endmodule // test_remote_event_map_push_format
